// *** src/shared_pin_ctrl.sv ***
// Control of port 5 pins 2 and 3 (shared with analog channels 10 and 11)
// and of the port 0 pin 2 / serial output pad, with an APB register file.
// Assumes a synchronous APB master and pad inputs from outside the clock domain.
`timescale 1ns/1ns
module shared_pin_ctrl
  import shared_pin_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] i_port5_pad,
  input wire logic i_serial_pad,
  input wire logic i_serial_data,
  output pin_drive_t o_pin2_drive,
  output pin_drive_t o_pin3_drive,
  output pin_drive_t o_serial_drive,
  output logic o_analog_channel_ten,
  output logic o_analog_channel_eleven
);

  // Register file state
  logic [7:0] pin_data_latch_q;
  logic [3:0] port5_direction_reg_q;
  logic [3:0] analog_select_reg_b_q;
  logic [3:0] misc_config_reg_q;
  logic [3:0] peripheral_mode_reg_q;
  logic [3:0] converter_channel_select_q;
  logic [2:0] pin_status_q;
  logic [31:0] prdata_q;

  // Pad input synchronisers
  logic [2:0] pad_s1_q;
  logic [2:0] pad_s2_q;
  logic [2:0] pad_s3_q;

  logic wr_en;
  logic setup_rd;
  logic [2:0] pad_raw;
  pin_cfg_t pin2_cfg;
  pin_cfg_t pin3_cfg;
  pin_cfg_t serial_cfg;
  pin_drive_t pin2_drive_d;
  pin_drive_t pin3_drive_d;
  pin_drive_t serial_drive_d;
  logic serial_level;

  // Address hit check, shared by decode and error
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == DATA_LATCH_OFS) || (addr == DIRECTION_OFS) ||
                  (addr == ANALOG_SEL_OFS) || (addr == MISC_CFG_OFS) ||
                  (addr == PERIPH_MODE_OFS) || (addr == CONV_CH_OFS) ||
                  (addr == PIN_STATUS_OFS);
  endfunction : addr_mapped

  // Read value of one register
  function automatic logic [31:0] read_value(input logic [7:0] addr, input logic [7:0] latch,
                                            input logic [3:0] dir, input logic [3:0] asel,
                                            input logic [3:0] misc, input logic [3:0] pmode,
                                            input logic [3:0] chan, input logic [2:0] stat);
    read_value = '0;
    unique case (addr)
      DATA_LATCH_OFS: read_value = {24'h00_0000, latch};
      DIRECTION_OFS: read_value = {28'h000_0000, dir};
      ANALOG_SEL_OFS: read_value = {28'h000_0000, asel};
      MISC_CFG_OFS: read_value = {28'h000_0000, misc};
      PERIPH_MODE_OFS: read_value = {28'h000_0000, pmode};
      CONV_CH_OFS: read_value = {28'h000_0000, chan};
      PIN_STATUS_OFS: read_value = {29'h0000_0000, stat};
      default: read_value = '0;
    endcase
  endfunction : read_value

  // APB handshake: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign wr_en = psel && penable && pwrite && addr_mapped(paddr);
  assign setup_rd = psel && !penable && !pwrite;
  assign prdata = prdata_q;

  // Read data captured in the setup cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata_q <= '0;
    end else if (setup_rd) begin
      prdata_q <= read_value(paddr, pin_data_latch_q, port5_direction_reg_q, analog_select_reg_b_q,
                             misc_config_reg_q, peripheral_mode_reg_q, converter_channel_select_q,
                             pin_status_q);
    end
  end

  // Data latches, all ones after reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_data_latch_q <= DATA_LATCH_RST;
    end else if (wr_en && paddr == DATA_LATCH_OFS) begin
      pin_data_latch_q <= pwdata[7:0];
    end
  end

  // Direction and analog select
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port5_direction_reg_q <= DIRECTION_RST;
      analog_select_reg_b_q <= ANALOG_SEL_RST;
    end else begin
      if (wr_en && paddr == DIRECTION_OFS) begin
        port5_direction_reg_q <= pwdata[3:0];
      end
      if (wr_en && paddr == ANALOG_SEL_OFS) begin
        analog_select_reg_b_q <= pwdata[3:0];
      end
    end
  end

  // Misc config, peripheral mode, converter channel
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      misc_config_reg_q <= MISC_CFG_RST;
      peripheral_mode_reg_q <= PERIPH_MODE_RST;
      converter_channel_select_q <= CONV_CH_RST;
    end else begin
      if (wr_en && paddr == MISC_CFG_OFS) begin
        misc_config_reg_q <= pwdata[3:0];
      end
      if (wr_en && paddr == PERIPH_MODE_OFS) begin
        peripheral_mode_reg_q <= pwdata[3:0];
      end
      if (wr_en && paddr == CONV_CH_OFS) begin
        converter_channel_select_q <= pwdata[3:0];
      end
    end
  end

  // Three-stage pad synchronisers
  assign pad_raw = {i_serial_pad, i_port5_pad};
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pad_s1_q <= '0;
      pad_s2_q <= '0;
      pad_s3_q <= '0;
    end else begin
      pad_s1_q <= pad_raw;
      pad_s2_q <= pad_s1_q;
      pad_s3_q <= pad_s2_q;
    end
  end

  // Pin level accepted once stages two and three agree; analog pins read 0
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_status_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pad_s2_q[i] == pad_s3_q[i]) begin
          pin_status_q[i] <= pad_s3_q[i];
        end
      end
      if (analog_select_reg_b_q[PORT5_ANALOG_SELECT_POS]) begin
        pin_status_q[1:0] <= 2'h0;
      end
    end
  end

  // Pad configurations; pins 2 and 3 share one analog select bit
  always_comb begin
    pin2_cfg.analog_sel = analog_select_reg_b_q[PORT5_ANALOG_SELECT_POS];
    pin2_cfg.pullup_en = misc_config_reg_q[PULLUP_ENABLE_POS];
    pin2_cfg.dir_out = port5_direction_reg_q[2];
    pin2_cfg.latch = pin_data_latch_q[2];
    pin2_cfg.open_drain = 1'b0;
    pin3_cfg.analog_sel = analog_select_reg_b_q[PORT5_ANALOG_SELECT_POS];
    pin3_cfg.pullup_en = misc_config_reg_q[PULLUP_ENABLE_POS];
    pin3_cfg.dir_out = port5_direction_reg_q[3];
    pin3_cfg.latch = pin_data_latch_q[3];
    pin3_cfg.open_drain = 1'b0;
  end

  // Serial-output pad: port latch or serial data, output forced in serial mode
  assign serial_level = peripheral_mode_reg_q[SERIAL_OUT_SELECT_POS] ?
                        i_serial_data : pin_data_latch_q[PORT0_LATCH_POS + SERIAL_PIN_POS];
  always_comb begin
    serial_cfg.analog_sel = 1'b0;
    serial_cfg.pullup_en = misc_config_reg_q[PULLUP_ENABLE_POS];
    serial_cfg.dir_out = peripheral_mode_reg_q[SERIAL_OUT_SELECT_POS] || port5_direction_reg_q[0];
    serial_cfg.latch = serial_level;
    serial_cfg.open_drain = misc_config_reg_q[OPEN_DRAIN_OPTION_POS];
  end

  shared_pin_drive u_pin2 (
    .i_cfg(pin2_cfg),
    .o_drive(pin2_drive_d)
  );

  shared_pin_drive u_pin3 (
    .i_cfg(pin3_cfg),
    .o_drive(pin3_drive_d)
  );

  shared_pin_drive u_serial (
    .i_cfg(serial_cfg),
    .o_drive(serial_drive_d)
  );

  // Registered pad controls
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin2_drive <= '0;
      o_pin3_drive <= '0;
      o_serial_drive <= '0;
    end else begin
      o_pin2_drive <= pin2_drive_d;
      o_pin3_drive <= pin3_drive_d;
      o_serial_drive <= serial_drive_d;
    end
  end

  // Converter routing follows channel select only
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_analog_channel_ten <= 1'b0;
      o_analog_channel_eleven <= 1'b0;
    end else begin
      o_analog_channel_ten <= converter_channel_select_q == CHANNEL_TEN;
      o_analog_channel_eleven <= converter_channel_select_q == CHANNEL_ELEVEN;
    end
  end

endmodule : shared_pin_ctrl

// *** src/shared_pin_pkg.sv ***
// Shared constants and types for the port/analog shared pin control block.
// Assumes a 32-bit APB register bus and one 20 MHz clock.
package shared_pin_pkg;

  // Register byte offsets
  localparam logic [7:0] DATA_LATCH_OFS = 8'h00;
  localparam logic [7:0] DIRECTION_OFS = 8'h04;
  localparam logic [7:0] ANALOG_SEL_OFS = 8'h08;
  localparam logic [7:0] MISC_CFG_OFS = 8'h0C;
  localparam logic [7:0] PERIPH_MODE_OFS = 8'h10;
  localparam logic [7:0] CONV_CH_OFS = 8'h14;
  localparam logic [7:0] PIN_STATUS_OFS = 8'h18;

  // Field positions
  localparam int PORT5_ANALOG_SELECT_POS = 2;
  localparam int OPEN_DRAIN_OPTION_POS = 2;
  localparam int PULLUP_ENABLE_POS = 3;
  localparam int SERIAL_OUT_SELECT_POS = 0;
  localparam int PORT0_LATCH_POS = 4;
  localparam int SERIAL_PIN_POS = 2;

  // Reset values
  localparam logic [7:0] DATA_LATCH_RST = 8'hFF;
  localparam logic [3:0] DIRECTION_RST = 4'h0;
  localparam logic [3:0] ANALOG_SEL_RST = 4'h0;
  localparam logic [3:0] MISC_CFG_RST = 4'h0;
  localparam logic [3:0] PERIPH_MODE_RST = 4'h0;
  localparam logic [3:0] CONV_CH_RST = 4'h0;

  // Converter channel numbers of the two shared pins
  localparam logic [3:0] CHANNEL_TEN = 4'hA;
  localparam logic [3:0] CHANNEL_ELEVEN = 4'hB;

  // Transistor controls of one pad
  typedef struct packed {
    logic pmos_on;
    logic nmos_on;
    logic pullup_on;
  } pin_drive_t;

  // Pin configuration as seen by one pad
  typedef struct packed {
    logic analog_sel;
    logic pullup_en;
    logic dir_out;
    logic latch;
    logic open_drain;
  } pin_cfg_t;

endpackage : shared_pin_pkg

// *** src/shared_pin_drive.sv ***
// Transistor decode for one port pad, digital or analog-shared.
// Assumes the configuration comes from flip-flops on the same clock.
`timescale 1ns/1ns
module shared_pin_drive
  import shared_pin_pkg::*;
(
  input wire pin_cfg_t i_cfg,
  output pin_drive_t o_drive
);

  // Output buffer and pull-up selection
  always_comb begin
    o_drive = '0;
    if (!i_cfg.analog_sel && i_cfg.dir_out) begin
      o_drive.pmos_on = i_cfg.latch && !i_cfg.open_drain;
      o_drive.nmos_on = !i_cfg.latch;
    end
    // Analog select leaves both buffer transistors off
    if (i_cfg.analog_sel) begin
      o_drive.pmos_on = 1'b0;
      o_drive.nmos_on = 1'b0;
      o_drive.pullup_on = i_cfg.pullup_en && i_cfg.latch;
    end else begin
      o_drive.pullup_on = i_cfg.pullup_en && i_cfg.latch && !i_cfg.dir_out;
    end
  end

endmodule : shared_pin_drive

// *** verification/shared_pin_ctrl_assertions.sv ***
// Checker for the shared pin control block ports.
// Assumes it is bound into every instance of the block.
`timescale 1ns/1ns
module shared_pin_ctrl_assertions
  import shared_pin_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire pin_drive_t o_pin2_drive,
  input wire pin_drive_t o_pin3_drive,
  input wire pin_drive_t o_serial_drive,
  input wire logic o_analog_channel_ten,
  input wire logic o_analog_channel_eleven
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic wr;
  // Completed write access
  assign wr = psel && penable && pwrite;
  property p_no_fight;
    o_pin2_drive[2:1] != 2'h3 && o_pin3_drive[2:1] != 2'h3 && o_serial_drive[2:1] != 2'h3;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both buffer transistors on");
  property p_pull_excl;
    (o_pin2_drive[2:1] != 2'h0 |-> !o_pin2_drive.pullup_on) and
    (o_pin3_drive[2:1] != 2'h0 |-> !o_pin3_drive.pullup_on);
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("pull-up on with output driven");
  property p_reset_off;
    $rose(i_rst_b) |-> ({o_pin2_drive, o_pin3_drive, o_serial_drive} == 9'h000)[*2];
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("drive on after reset");
  property p_chan_excl;
    !(o_analog_channel_ten && o_analog_channel_eleven);
  endproperty
  a_chan_excl: assert property (p_chan_excl) else $error("two channels routed");
  property p_drive_by_write;
    !$stable({o_pin2_drive, o_pin3_drive}) |-> $past(wr, 2);
  endproperty
  a_drive_by_write: assert property (p_drive_by_write) else $error("drive changed without write");
  property p_chan_by_write;
    $changed(o_analog_channel_ten) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_chan_by_write: assert property (p_chan_by_write) else $error("channel changed without write");
  property p_err;
    (psel && penable && paddr > 8'h18 |-> pslverr) and (pslverr |-> psel && penable);
  endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_ready;
    psel |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  // Main scenarios reached
  c_pull: cover property (o_pin2_drive.pullup_on && o_pin3_drive.pullup_on);
  c_chan: cover property (o_analog_channel_eleven);
  c_err: cover property (pslverr);
endmodule : shared_pin_ctrl_assertions

bind shared_pin_ctrl shared_pin_ctrl_assertions chk_u (.i_clk, .i_rst_b, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .o_pin2_drive, .o_pin3_drive, .o_serial_drive, .o_analog_channel_ten,
  .o_analog_channel_eleven);

// *** verification/shared_pin_board.sv ***
// Board model: resolves the three pads from the drive controls.
// Assumes undriven pads float; a floating pad toggles every cycle.
`timescale 1ns/1ns
module shared_pin_board
  import shared_pin_pkg::*;
(
  input wire logic i_clk,
  input wire pin_drive_t i_pin2,
  input wire pin_drive_t i_pin3,
  input wire pin_drive_t i_serial,
  output logic [1:0] o_port5_pad,
  output logic o_serial_pad
);
  logic flt_q = 1'h0;
  // Floating level changes every cycle
  always @(posedge i_clk) flt_q <= ~flt_q;
  function automatic logic lvl(pin_drive_t p, logic f);
    return p.nmos_on ? 1'h0 : (p.pmos_on || p.pullup_on) ? 1'h1 : f;
  endfunction : lvl
  // Pad levels seen by the block
  always_comb begin
    o_port5_pad = {lvl(i_pin3, flt_q), lvl(i_pin2, flt_q)};
    o_serial_pad = lvl(i_serial, ~flt_q);
  end
endmodule : shared_pin_board

// *** verification/shared_pin_ctrl_tb.sv ***
// Testbench for the shared pin control block.
// Assumes the board model on the pads and the bound checker.
`timescale 1ns/1ns
module shared_pin_ctrl_tb;
  import shared_pin_pkg::*;
  logic i_clk = 1'h0, i_rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, i_serial_data = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, ten, elev, sp;
  logic [1:0] p5;
  pin_drive_t d2, d3, ds;
  int fails = 0, compares = 0;
  shared_pin_ctrl dut_u (.i_clk, .i_rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .i_port5_pad(p5), .i_serial_pad(sp), .i_serial_data, .o_pin2_drive(d2), .o_pin3_drive(d3),
    .o_serial_drive(ds), .o_analog_channel_ten(ten), .o_analog_channel_eleven(elev));
  shared_pin_board board_u (.i_clk, .i_pin2(d2), .i_pin3(d3), .i_serial(ds), .o_port5_pad(p5),
    .o_serial_pad(sp));
  // Clock
  initial forever #25 i_clk = ~i_clk;
  function automatic logic [2:0] exp_drv(logic a, logic e, logic d, logic l);
    if (a) return {2'h0, e & l};
    return {d & l, d & !l, e & l & !d};
  endfunction : exp_drv
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer, released after the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'h1;
    do @(posedge i_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic settle();
    repeat (2) @(negedge i_clk);
  endtask : settle
  task automatic t_reset();
    apb(1'h0, DATA_LATCH_OFS, '0);
    chk("latch", rd, 32'h0000_00FF);
    chk("drive", {d2, d3, ds}, '0);
  endtask : t_reset
  // Every mix of select, pull-up enable, direction and latch
  task automatic t_pins();
    logic [5:0] c;
    for (int i = 0; i < 64; i++) begin
      c = 6'(i);
      apb(1'h1, DATA_LATCH_OFS, {24'h0, 4'hF, c[1:0], 2'h3});
      apb(1'h1, DIRECTION_OFS, {28'h0, c[3:2], 2'h0});
      apb(1'h1, ANALOG_SEL_OFS, {29'h0, c[5], 2'h0});
      apb(1'h1, MISC_CFG_OFS, {28'h0, c[4], 3'h0});
      settle();
      chk("pin2", d2, exp_drv(c[5], c[4], c[2], c[0]));
      chk("pin3", d3, exp_drv(c[5], c[4], c[3], c[1]));
    end
  endtask : t_pins
  // Serial pad in port and serial modes, push-pull and open drain
  task automatic t_serial();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      @(posedge i_clk);
      i_serial_data <= c[0];
      apb(1'h1, DATA_LATCH_OFS, {24'h0, 1'h1, c[0], 6'h3F});
      apb(1'h1, DIRECTION_OFS, 32'h0000_0001);
      apb(1'h1, MISC_CFG_OFS, {29'h0, c[1], 2'h0});
      apb(1'h1, PERIPH_MODE_OFS, {31'h0, c[2]});
      settle();
      chk("serial", {ds.pmos_on, ds.nmos_on}, {c[0] & !c[1], !c[0]});
    end
  endtask : t_serial
  task automatic t_chan();
    for (int i = 9; i < 12; i++) begin
      apb(1'h1, CONV_CH_OFS, 32'(i));
      settle();
      chk("channel", {ten, elev}, {i == 10, i == 11});
    end
  endtask : t_chan
  // Unmapped access, safe switch to analog, then pad read-back
  task automatic t_err_status();
    apb(1'h1, 8'h1C, 32'hFFFF_FFFF);
    chk("wr_err", err, 1'h1);
    apb(1'h0, 8'h1C, '0);
    chk("rd_err", err, 1'h1);
    chk("rd_data", rd, '0);
    apb(1'h1, DATA_LATCH_OFS, 32'h0000_00F3);
    apb(1'h1, MISC_CFG_OFS, '0);
    apb(1'h1, ANALOG_SEL_OFS, 32'h0000_0004);
    settle();
    chk("analog_drive", {d2, d3}, '0);
    apb(1'h0, PIN_STATUS_OFS, '0);
    chk("analog_status", rd[1:0], '0);
    apb(1'h1, ANALOG_SEL_OFS, '0);
    apb(1'h1, DIRECTION_OFS, 32'h0000_0004);
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, DATA_LATCH_OFS, i ? 32'h0000_00FB : 32'h0000_00FF);
      repeat (8) @(posedge i_clk);
      apb(1'h0, PIN_STATUS_OFS, '0);
      chk("status", rd[0], i == 0);
    end
  endtask : t_err_status
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence, with a second reset mid-run
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'h1;
    t_reset();
    t_pins();
    t_serial();
    t_chan();
    t_err_status();
    @(posedge i_clk);
    i_rst_b <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'h1;
    t_reset();
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    report_and_stop();
  end
endmodule : shared_pin_ctrl_tb
